// ---- rtl/fsc_bus_cycle.sv ----
`timescale 1ns/1ps
`include "fsc_regs.svh"
module fsc_bus_cycle #(
    parameter int AW = 23,
    parameter int DW = 16,
    parameter int ACC_CYC = `FSC_ACC_CYC,
    parameter int PULSE_CYC = `FSC_WPULSE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request from the sequencer
    input wire logic start_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] data_i,
    output logic done_o,
    output logic [DW-1:0] rdata_o,
    // flash pins
    output logic [AW-1:0] flash_addr_o,
    output logic [DW-1:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [DW-1:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o
);
    ////////////////////////////////////////////////////////////////
    fsc_pkg::fsc_cyc_state_t st; // cycle phase
    logic [7:0] cnt; // phase down-counter
    logic is_wr; // current cycle is a write
    logic [DW-1:0] dq_s1; // first sync stage, read only by dq_s2
    logic [DW-1:0] dq_s2; // synchronised data bus

    // data bus comes from another chip, two flops before use
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end
        else
        begin
            dq_s1 <= flash_dq_i;
            dq_s2 <= dq_s1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // one strobe cycle; reads hold oe two extra cycles to cover the synchroniser
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st <= fsc_pkg::FSC_CY_IDLE;
            cnt <= 8'h00;
            is_wr <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= '0;
            flash_addr_o <= '0;
            flash_dq_o <= '0;
            flash_dq_oe_o <= 1'b0;
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
        end
        else
        begin
            done_o <= 1'b0;
            unique case (st)
                fsc_pkg::FSC_CY_IDLE:
                begin
                    if (start_i)
                    begin
                        // address and chip enable go out with the strobe
                        flash_addr_o <= addr_i;
                        flash_ce_n_o <= 1'b0;
                        is_wr <= wr_i;
                        st <= fsc_pkg::FSC_CY_ACTIVE;
                        if (wr_i)
                        begin
                            flash_dq_o <= data_i;
                            flash_dq_oe_o <= 1'b1;
                            flash_we_n_o <= 1'b0;
                            cnt <= 8'(PULSE_CYC - 1);
                        end
                        else
                        begin
                            flash_oe_n_o <= 1'b0;
                            cnt <= 8'(ACC_CYC + 1);
                        end
                    end
                end
                fsc_pkg::FSC_CY_ACTIVE:
                begin
                    if (cnt == 8'h00)
                    begin
                        // device latches write data on the rising we edge
                        flash_we_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        if (!is_wr)
                        begin
                            rdata_o <= dq_s2;
                        end
                        st <= fsc_pkg::FSC_CY_RECOV;
                    end
                    else
                    begin
                        cnt <= cnt - 8'h01;
                    end
                end
                fsc_pkg::FSC_CY_RECOV:
                begin
                    // data held one cycle past we rise for hold time
                    flash_ce_n_o <= 1'b1;
                    flash_dq_oe_o <= 1'b0;
                    done_o <= 1'b1;
                    st <= fsc_pkg::FSC_CY_IDLE;
                end
                default:
                begin
                    st <= fsc_pkg::FSC_CY_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- rtl/fsc_pkg.sv ----
package fsc_pkg;
    // operations that software may start
    typedef enum logic [2:0] {
        FSC_OP_NONE = 3'b000,
        FSC_OP_WRITE = 3'b001,
        FSC_OP_READ = 3'b010,
        FSC_OP_STATUS = 3'b011,
        FSC_OP_CLEAR = 3'b100,
        FSC_OP_POLL = 3'b101,
        FSC_OP_ABORT_RST = 3'b110,
        FSC_OP_RESET = 3'b111
    } fsc_op_t;

    // sequencer states
    typedef enum logic [1:0] {
        FSC_ST_IDLE = 2'b00,
        FSC_ST_ISSUE = 2'b01,
        FSC_ST_WAIT = 2'b10,
        FSC_ST_DONE = 2'b11
    } fsc_state_t;

    // pin cycle state
    typedef enum logic [1:0] {
        FSC_CY_IDLE = 2'b00,
        FSC_CY_ACTIVE = 2'b01,
        FSC_CY_RECOV = 2'b10
    } fsc_cyc_state_t;

    // one flash bus cycle of a sequence
    typedef struct packed {
        logic last;
        logic wr;
        logic [22:0] addr;
        logic [15:0] data;
    } fsc_cycle_t;
endpackage

// ---- rtl/fsc_regs.svh ----
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// apb register byte offsets
`define FSC_OFF_CTRL 8'h00
`define FSC_OFF_ADDR 8'h04
`define FSC_OFF_WDATA 8'h08
`define FSC_OFF_RDATA 8'h0C
`define FSC_OFF_STAT 8'h10
`define FSC_OFF_SWORD 8'h14
`define FSC_OFF_POLL 8'h18

// control register fields
`define FSC_CTRL_GO 0
`define FSC_CTRL_SUSP 4

// status register fields
`define FSC_STAT_DONE 1

// poll and status word bit positions
`define FSC_PB_VALID 7
`define FSC_PB_TOG 6
`define FSC_PB_FAIL 5
`define FSC_PB_RSV_HI 4
`define FSC_PB_SUSP 3
`define FSC_PB_TOG2 2
`define FSC_PB_ABORT 1
`define FSC_PB_RSV_LO 0

// command words and unlock addresses
`define FSC_CMD_UNLOCK1 16'h00AA
`define FSC_CMD_UNLOCK2 16'h0055
`define FSC_CMD_RESET 16'h00F0
`define FSC_CMD_SR_READ 16'h0070
`define FSC_CMD_SR_CLEAR 16'h0071
`define FSC_ADDR_UNLOCK1 23'h00_0555
`define FSC_ADDR_UNLOCK2 23'h00_02AA

// reset values
`define FSC_RST_SWORD 8'h00

// timing
`define FSC_CLK_MHZ 10
`define FSC_T_ACCESS_NS 70
`define FSC_T_WPULSE_NS 35
`define FSC_ACC_CYC ((`FSC_T_ACCESS_NS * `FSC_CLK_MHZ + 999) / 1000)
`define FSC_WPULSE_CYC ((`FSC_T_WPULSE_NS * `FSC_CLK_MHZ + 999) / 1000)
`endif

// ---- rtl/fsc_top.sv ----
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "fsc_regs.svh"
module fsc_top #(
    parameter int AW = 23,
    parameter int DW = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // flash pins
    output logic [AW-1:0] flash_addr_o,
    output logic [DW-1:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [DW-1:0] flash_dq_i,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    input wire logic ready_busy_n_output_i
);
    ////////////////////////////////////////////////////////////////
    fsc_pkg::fsc_state_t st; // sequencer state
    fsc_pkg::fsc_op_t op; // operation in progress
    logic [1:0] step; // cycle index within the sequence
    logic susp_erase; // software says an erase was suspended
    logic [AW-1:0] addr_reg; // target address
    logic [DW-1:0] wdata_reg; // write data for plain writes
    logic [DW-1:0] rdata; // last word read
    logic [DW-1:0] rd_prev; // last word read, poll-masked
    logic [DW-1:0] poll_masked; // poll word with don't-care bits cleared
    logic [7:0] status_word; // captured device status word
    logic done_flag; // sticky completion flag
    logic tog6; // poll bit 6 toggled
    logic tog2; // poll bit 2 toggled, masked when meaningless
    logic rb_s1; // first sync stage of ready/busy
    logic rb_s2; // synchronised ready/busy
    logic cyc_start; // pulse to the pin cycle engine
    logic cyc_done; // pin cycle finished
    logic [DW-1:0] cyc_rdata; // data from the pin cycle
    fsc_pkg::fsc_cycle_t cur; // current sequence entry
    logic apb_wr; // apb write takes effect
    logic apb_go; // software start request
    logic last_was_rd; // finished cycle was a read

    ////////////////////////////////////////////////////////////////
    // sequence table: which pin cycles each operation issues
    function automatic fsc_pkg::fsc_cycle_t seq_item(fsc_pkg::fsc_op_t o, logic [1:0] s,
                                                     logic [AW-1:0] a, logic [DW-1:0] d);
        fsc_pkg::fsc_cycle_t c;
        c = '{last: 1'b1, wr: 1'b0, addr: a, data: d};
        unique case (o)
            fsc_pkg::FSC_OP_WRITE: c.wr = 1'b1;
            fsc_pkg::FSC_OP_READ: c.last = 1'b1;
            fsc_pkg::FSC_OP_STATUS:
            begin
                // status read enter, then one read returns the word
                if (s == 2'd0)
                begin
                    c = '{last: 1'b0, wr: 1'b1, addr: `FSC_ADDR_UNLOCK1, data: `FSC_CMD_SR_READ};
                end
            end
            fsc_pkg::FSC_OP_CLEAR:
            begin
                c = '{last: 1'b1, wr: 1'b1, addr: `FSC_ADDR_UNLOCK1, data: `FSC_CMD_SR_CLEAR};
            end
            fsc_pkg::FSC_OP_POLL: c.last = (s == 2'd1);
            fsc_pkg::FSC_OP_ABORT_RST:
            begin
                // three-cycle abort reset: unlock, unlock, reset
                unique case (s)
                    2'd0: c = '{last: 1'b0, wr: 1'b1, addr: `FSC_ADDR_UNLOCK1, data: `FSC_CMD_UNLOCK1};
                    2'd1: c = '{last: 1'b0, wr: 1'b1, addr: `FSC_ADDR_UNLOCK2, data: `FSC_CMD_UNLOCK2};
                    default: c = '{last: 1'b1, wr: 1'b1, addr: `FSC_ADDR_UNLOCK1, data: `FSC_CMD_RESET};
                endcase
            end
            fsc_pkg::FSC_OP_RESET:
            begin
                c = '{last: 1'b1, wr: 1'b1, addr: a, data: `FSC_CMD_RESET};
            end
            default: c.last = 1'b1;
        endcase
        return c;
    endfunction

    assign cur = seq_item(op, step, addr_reg, wdata_reg);
    assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    assign apb_go = apb_wr & (paddr_i == `FSC_OFF_CTRL) & pwdata_i[`FSC_CTRL_GO];

    // host never trusts reserved poll bits 4,0; poll bits 3,2 not when bit 1 shows abort without a suspended erase
    always_comb
    begin
        poll_masked = cyc_rdata;
        poll_masked[`FSC_PB_RSV_HI] = 1'b0;
        poll_masked[`FSC_PB_RSV_LO] = 1'b0;
        if (cyc_rdata[`FSC_PB_ABORT] && !susp_erase)
        begin
            poll_masked[`FSC_PB_SUSP] = 1'b0;
            poll_masked[`FSC_PB_TOG2] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // ready/busy comes from the pin, synchronise before use
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rb_s1 <= 1'b0;
            rb_s2 <= 1'b0;
        end
        else
        begin
            rb_s1 <= ready_busy_n_output_i;
            rb_s2 <= rb_s1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // apb handshake: one wait cycle so that prdata is registered
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else
        begin
            pready_o <= psel_i & penable_i & ~pready_o;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_o)
            begin
                unique case (paddr_i)
                    `FSC_OFF_CTRL: prdata_o <= {27'h000_0000, susp_erase, op, 1'b0};
                    `FSC_OFF_ADDR: prdata_o <= 32'(addr_reg);
                    `FSC_OFF_WDATA: prdata_o <= 32'(wdata_reg);
                    `FSC_OFF_RDATA: prdata_o <= 32'(rdata);
                    `FSC_OFF_STAT:
                    begin
                        // status-word error bits count only once its valid bit is seen
                        prdata_o <= {23'h00_0000,
                                     status_word[`FSC_PB_VALID] & (status_word[`FSC_PB_FAIL]
                                         | status_word[`FSC_PB_RSV_HI] | status_word[`FSC_PB_SUSP]
                                         | status_word[`FSC_PB_ABORT]),
                                     status_word[`FSC_PB_VALID],
                                     rdata[`FSC_PB_FAIL], rdata[`FSC_PB_ABORT], tog2, tog6,
                                     rb_s2, done_flag, (st != fsc_pkg::FSC_ST_IDLE)};
                    end
                    `FSC_OFF_SWORD: prdata_o <= 32'(status_word);
                    `FSC_OFF_POLL: prdata_o <= 32'(rd_prev);
                    default: pslverr_o <= 1'b1; // unmapped or misaligned address
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // software-written configuration
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_reg <= '0;
            wdata_reg <= '0;
            susp_erase <= 1'b0;
        end
        else if (apb_wr)
        begin
            unique case (paddr_i)
                `FSC_OFF_ADDR: addr_reg <= pwdata_i[AW-1:0];
                `FSC_OFF_WDATA: wdata_reg <= pwdata_i[DW-1:0];
                `FSC_OFF_CTRL: susp_erase <= pwdata_i[`FSC_CTRL_SUSP];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // sequencer: issues the table entries one pin cycle at a time
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st <= fsc_pkg::FSC_ST_IDLE;
            op <= fsc_pkg::FSC_OP_NONE;
            step <= 2'd0;
            cyc_start <= 1'b0;
            last_was_rd <= 1'b0;
        end
        else
        begin
            cyc_start <= 1'b0;
            unique case (st)
                fsc_pkg::FSC_ST_IDLE:
                begin
                    // a start while busy is dropped; op none does nothing
                    if (apb_go && pwdata_i[3:1] != 3'b000)
                    begin
                        op <= fsc_pkg::fsc_op_t'(pwdata_i[3:1]);
                        step <= 2'd0;
                        st <= fsc_pkg::FSC_ST_ISSUE;
                    end
                end
                fsc_pkg::FSC_ST_ISSUE:
                begin
                    cyc_start <= 1'b1;
                    last_was_rd <= ~cur.wr;
                    st <= fsc_pkg::FSC_ST_WAIT;
                end
                fsc_pkg::FSC_ST_WAIT:
                begin
                    if (cyc_done)
                    begin
                        if (cur.last)
                        begin
                            st <= fsc_pkg::FSC_ST_DONE;
                        end
                        else
                        begin
                            step <= step + 2'd1;
                            st <= fsc_pkg::FSC_ST_ISSUE;
                        end
                    end
                end
                fsc_pkg::FSC_ST_DONE:
                begin
                    st <= fsc_pkg::FSC_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // read results: raw word, masked poll word, toggles, status word
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata <= '0;
            rd_prev <= '0;
            tog6 <= 1'b0;
            tog2 <= 1'b0;
            status_word <= `FSC_RST_SWORD;
        end
        else if (cyc_done && last_was_rd)
        begin
            rdata <= cyc_rdata;
            rd_prev <= poll_masked;
            if (op == fsc_pkg::FSC_OP_POLL && step == 2'd1)
            begin
                // compare both reads; bit 2 compared on masked words only
                tog6 <= rdata[`FSC_PB_TOG] ^ cyc_rdata[`FSC_PB_TOG];
                tog2 <= rd_prev[`FSC_PB_TOG2] ^ poll_masked[`FSC_PB_TOG2];
            end
            if (op == fsc_pkg::FSC_OP_STATUS)
            begin
                status_word <= cyc_rdata[7:0];
            end
        end
        else if (cyc_done && (op == fsc_pkg::FSC_OP_CLEAR || op == fsc_pkg::FSC_OP_ABORT_RST))
        begin
            // either exit command drops the remembered error word
            status_word <= `FSC_RST_SWORD;
        end
    end

    ////////////////////////////////////////////////////////////////
    // sticky done flag: completion wins over a same-cycle clear
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            done_flag <= 1'b0;
        end
        else if (st == fsc_pkg::FSC_ST_DONE)
        begin
            done_flag <= 1'b1;
        end
        else if (apb_wr && paddr_i == `FSC_OFF_STAT && pwdata_i[`FSC_STAT_DONE])
        begin
            done_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    fsc_bus_cycle #(
        .AW(AW),
        .DW(DW),
        .ACC_CYC(`FSC_ACC_CYC),
        .PULSE_CYC(`FSC_WPULSE_CYC)
    ) u_cycle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(cyc_start),
        .wr_i(cur.wr),
        .addr_i(cur.addr),
        .data_i(cur.data),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .flash_addr_o(flash_addr_o),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe_o(flash_dq_oe_o),
        .flash_dq_i(flash_dq_i),
        .flash_ce_n_o(flash_ce_n_o),
        .flash_oe_n_o(flash_oe_n_o),
        .flash_we_n_o(flash_we_n_o)
    );
endmodule

// ---- test/fsc_flash_model.sv ----
`timescale 1ns/1ps
module fsc_flash_model #(
    parameter int AW = 23,
    parameter int DW = 16,
    parameter int PROT_NS = 30000
) (
    // pins from the controller
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] dq_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    // answers
    output logic [DW-1:0] dq_o,
    output logic ready_busy_n_output_o
);
    int st = 0; // 0 read, 1 and 2 unlock, 3 program, 4 buffer load
    logic pe = 1'b0; // protect busy
    logic ab = 1'b0; // buffer abort
    logic srd = 1'b0; // status read armed
    logic tog = 1'b0;
    logic [7:0] sw = 8'h00;
    logic [DW-1:0] last = '0;
    // open drain, pulled high unless busy
    assign ready_busy_n_output_o = !(pe || ab);
    ////////////////////////////////////////
    // decode at write pulse end
    always @(posedge we_n_i)
    begin
        if (ce_n_i !== 1'b0) ;
        else if (dq_i[7:0] == 8'h70 && addr_i[11:0] == 12'h555) srd = 1'b1;
        else if (!pe)
            case (st)
                0: if (dq_i[7:0] == 8'hAA && addr_i[11:0] == 12'h555) st = 1;
                   else if (dq_i[7:0] == 8'h71 && addr_i[11:0] == 12'h555) {ab, sw} = 9'h000;
                1: st = (dq_i[7:0] == 8'h55 && addr_i[11:0] == 12'h2AA) ? 2 : 0;
                2: begin
                    st = 0;
                    if (ab) {ab, sw} = (dq_i[7:0] == 8'hF0) ? 9'h000 : {ab, sw};
                    else if (dq_i[7:0] == 8'hA0 && addr_i[11:0] == 12'h555) st = 3;
                    else if (dq_i[7:0] == 8'h25) st = 4;
                end
                3: {last, st, pe, sw} = {dq_i, 32'd0, addr_i[AW-1], 8'h00};
                4: {last, st, ab, sw} = {dq_i, 32'd0, addr_i[AW-2], addr_i[AW-2] ? 8'h98 : sw};
            endcase
    end
    // protect busy ends by itself after a fixed span
    always @(posedge pe)
    begin
        #PROT_NS;
        sw = 8'h92;
        pe = 1'b0;
    end
    // read word chosen as output enable falls
    always @(negedge oe_n_i)
    begin
        if (srd) {dq_o, srd} = {8'h00, sw, 1'b0};
        else if (pe || ab)
        begin
            tog = !tog;
            // reserved and unqualified bits driven high on purpose
            dq_o = {8'h00, !last[7], tog, 3'b011, pe ? tog : 1'b1, ab, 1'b1};
        end
        else dq_o = addr_i[DW-1:0] ^ 16'h5A5A;
    end
    // released bus must not keep the last word
    always @(posedge oe_n_i) dq_o = ~dq_o;
endmodule

// ---- test/fsc_top_properties.sv ----
`timescale 1ns/1ps
module fsc_top_properties #(
    parameter int AW = 23,
    parameter int DW = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // apb side
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // flash pins
    input wire logic [AW-1:0] flash_addr_o,
    input wire logic [DW-1:0] flash_dq_o,
    input wire logic flash_dq_oe_o,
    input wire logic [DW-1:0] flash_dq_i,
    input wire logic flash_ce_n_o,
    input wire logic flash_oe_n_o,
    input wire logic flash_we_n_o,
    input wire logic ready_busy_n_output_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // apb answers after exactly one wait state
    a_one_wait_state: assert property ($rose(penable_i) && psel_i |=> pready_o ##1 !pready_o)
        else $error("pready timing wrong");
    a_ready_needs_sel: assert property (!psel_i |-> !pready_o)
        else $error("pready without psel");
    a_bad_addr_err: assert property (pready_o && (paddr_i > 8'h18 || paddr_i[1:0] != 2'b00)
        |-> pslverr_o && prdata_o == 32'h0000_0000) else $error("unmapped access not refused");
    a_poll_reserved_masked: assert property (pready_o && !pwrite_i && paddr_i == 8'h18
        |-> !prdata_o[4] && !prdata_o[0]) else $error("reserved poll bits not masked");
    // flash strobes: never read and write at once
    a_no_dual_strobe: assert property (flash_oe_n_o || flash_we_n_o) else $error("oe and we both low");
    a_drive_on_write: assert property (!flash_we_n_o |-> flash_dq_oe_o && !flash_ce_n_o)
        else $error("write strobe without drive");
    a_write_pulse: assert property ($fell(flash_we_n_o) |=> flash_we_n_o && !flash_ce_n_o ##1 flash_ce_n_o)
        else $error("write cycle shape wrong");
    a_read_span: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o [*3] ##1 flash_oe_n_o)
        else $error("read strobe length wrong");
    // address steady through a cycle
    a_addr_held: assert property (!flash_ce_n_o && !$past(flash_ce_n_o) |-> $stable(flash_addr_o))
        else $error("address moved in cycle");
    c_refused: cover property (pslverr_o);
    c_write: cover property ($fell(flash_we_n_o));
    c_busy_read: cover property (!ready_busy_n_output_i && $fell(flash_oe_n_o));
endmodule
bind fsc_top fsc_top_properties #(.AW(AW), .DW(DW)) u_fsc_top_properties (.*);

// ---- test/tb_fsc_top.sv ----
`timescale 1ns/1ps
module tb_fsc_top;
    typedef struct { logic [7:0] a; logic [31:0] e; logic x; } fsc_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic pready_o, pslverr_o, er, flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, rb;
    logic [22:0] flash_addr_o;
    logic [15:0] flash_dq_o, mdl_dq, dq_bus;
    int fails = 0, compares = 0;
    // rows: address, read back after writing all ones, refused
    fsc_row_t rows [6] = '{'{8'h04, 32'h007F_FFFF, 1'b0}, '{8'h08, 32'h0000_FFFF, 1'b0},
        '{8'h0C, 32'h0000_0000, 1'b0}, '{8'h14, 32'h0000_0000, 1'b0}, '{8'h1C, 32'h0000_0000, 1'b1},
        '{8'h06, 32'h0000_0000, 1'b1}};
    // shared data wire: whoever enables wins
    assign dq_bus = flash_dq_oe_o ? flash_dq_o : mdl_dq;
    fsc_top u_fsc_top (.*, .flash_dq_i(dq_bus), .ready_busy_n_output_i(rb));
    fsc_flash_model #(.PROT_NS(30000)) u_fsc_flash_model (.addr_i(flash_addr_o), .dq_i(dq_bus),
        .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .dq_o(mdl_dq),
        .ready_busy_n_output_o(rb));
    initial forever #50 clk_i = !clk_i;
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        {rd, er} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(n, e, rd);
    endtask
    // start op, await done, clear it
    task automatic op(input logic [2:0] o, input logic h);
        apb(1'b1, 8'h00, {27'h0, h, o, 1'b1});
        do apb(1'b0, 8'h10, '0); while (rd[1] !== 1'b1);
        apb(1'b1, 8'h10, 32'h0000_0002);
    endtask
    task automatic fw(input logic [22:0] a, input logic [15:0] d);
        apb(1'b1, 8'h04, {9'h0, a});
        apb(1'b1, 8'h08, {16'h0, d});
        op(fsc_pkg::FSC_OP_WRITE, 1'b0);
    endtask
    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        end_sim();
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, 32'hFFFF_FFFF);
            chk("wr err", rows[i].x, er);
            apb(1'b0, rows[i].a, '0);
            chk("rd data", rows[i].e, rd);
            chk("rd err", rows[i].x, er);
        end
        $display("table done");
        // second reset in mid-run
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk("addr", 8'h04, 32'h0000_0000);
        rchk("stat", 8'h10, 32'h0000_0004);
        $display("reset done");
        // program into a protected place
        fw(23'h555, 16'h00AA);
        fw(23'h2AA, 16'h0055);
        fw(23'h555, 16'h00A0);
        fw(23'h40_0000, 16'h0080);
        apb(1'b1, 8'h04, 32'h0000_0123);
        op(fsc_pkg::FSC_OP_POLL, 1'b0);
        rchk("poll prot", 8'h18, 32'h0000_0008);
        apb(1'b0, 8'h10, '0);
        chk("stat prot", 32'h0000_0008, rd & 32'h0000_000C);
        op(fsc_pkg::FSC_OP_STATUS, 1'b0);
        rchk("sword busy", 8'h14, 32'h0000_0000);
        repeat (320) @(posedge clk_i);
        op(fsc_pkg::FSC_OP_STATUS, 1'b0);
        rchk("sword prot", 8'h14, 32'h0000_0092);
        apb(1'b0, 8'h10, '0);
        chk("stat err", 32'h0000_0184, rd & 32'h0000_0184);
        op(fsc_pkg::FSC_OP_CLEAR, 1'b0);
        rchk("sword clr", 8'h14, 32'h0000_0000);
        $display("protect done");
        // buffer load out of range aborts
        fw(23'h555, 16'h00AA);
        fw(23'h2AA, 16'h0055);
        fw(23'h00_1000, 16'h0025);
        fw(23'h20_1000, 16'h0000);
        op(fsc_pkg::FSC_OP_POLL, 1'b0);
        rchk("poll abort", 8'h18, 32'h0000_0082);
        op(fsc_pkg::FSC_OP_STATUS, 1'b0);
        rchk("sword abort", 8'h14, 32'h0000_0098);
        apb(1'b0, 8'h10, '0);
        chk("stat abort", 32'h0000_0180, rd & 32'h0000_0184);
        op(fsc_pkg::FSC_OP_POLL, 1'b1);
        rchk("poll hint", 8'h18, 32'h0000_008E);
        op(fsc_pkg::FSC_OP_ABORT_RST, 1'b0);
        rchk("sword arst", 8'h14, 32'h0000_0000);
        apb(1'b0, 8'h10, '0);
        chk("stat ready", 32'h0000_0004, rd & 32'h0000_0004);
        $display("abort done");
        // array read once ready again
        apb(1'b1, 8'h04, 32'h0000_1234);
        op(fsc_pkg::FSC_OP_READ, 1'b0);
        rchk("rdata", 8'h0C, 32'h0000_486E);
        op(fsc_pkg::FSC_OP_RESET, 1'b0);
        $display("read done");
        end_sim();
    end
endmodule
